// ### src/dac_frame_cfg.svh
// constants for the serial converter input frame
`ifndef DAC_FRAME_CFG_SVH
`define DAC_FRAME_CFG_SVH
`define FRAME_LEN_WIDE        24
`define FRAME_LEN_NARROW      16
`define DATA_RESET            24'h000000
`define LINK_CLK_MAX_MHZ      50
`define SYS_CLK_MHZ           250
`define LINK_CLK_MIN_SYS_CYC  ((`SYS_CLK_MHZ + `LINK_CLK_MAX_MHZ - 1) / `LINK_CLK_MAX_MHZ)
`endif

// ### src/dac_frame_pkg.sv
// types for the serial converter input frame
package dac_frame_pkg;
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_SHIFT = 2'b01,
    ST_DONE  = 2'b10
  } frame_state_type;

  typedef struct packed {
    logic frame_n;
    logic link_clk;
    logic data;
  } link_pins_type;
endpackage : dac_frame_pkg

// ### src/pin_sync.sv
// two-stage synchroniser for a group of pins
`timescale 1ns/1ps
module pin_sync #(
  parameter int WIDTH = 3
) (
  input  wire logic             i_sys_clk,
  input  wire logic             i_rst_b,
  input  wire logic [WIDTH-1:0] i_async,
  input  wire logic [WIDTH-1:0] i_reset_val,
  output logic      [WIDTH-1:0] o_sync
);
  logic [WIDTH-1:0] meta_r;

  // first stage feeds only the second stage
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      meta_r <= '1;
      o_sync <= '1;
    end else begin
      meta_r <= i_async;
      o_sync <= meta_r;
    end
  end

  // i_reset_val is unused hardware-wise; kept for width checks
  initial begin
    if (WIDTH < 1) $error("pin_sync width must be at least one");
  end
endmodule : pin_sync

// ### src/serial_dac_input_frame.sv
// serial write port of a single-channel voltage-output converter
// Operation
// RL1: shift data in on falling clock edges
// RL2: shift register 24 or 16 bits
// RL3: frame select low enables shifting
// RL4: update converter after final falling edge
// RL5: early frame select rise aborts frame
// RL6: host keeps serial clock at most 50MHz
// RL7: frame select fall clears bit counter
`timescale 1ns/1ps
`include "dac_frame_cfg.svh"
module serial_dac_input_frame #(
  parameter int  FRAME_LEN = `FRAME_LEN_WIDE
) (
  input  wire logic                          i_sys_clk,
  input  wire logic                          i_rst_b,
  input  wire dac_frame_pkg::link_pins_type  i_pins,
  output logic      [FRAME_LEN-1:0]          o_dac_word,
  output logic                               o_dac_update,
  output logic                               o_frame_abort,
  output logic                               o_frame_active
);
  localparam int CNT_W = $clog2(FRAME_LEN + 1);

  // ************************************************************
  // latency notes
  // ************************************************************
  // every pin passes two flip-flops; frame select and link clock pass one more for their delayed copies
  // a pin edge is seen as a one-cycle strobe about two cycles late
  // data and link clock share the same pipe, so their skew is kept
  // the data bit is taken in the cycle that sees the link clock fall
  // the word and update pulse leave one cycle after the last bit
  // an abort pulse leaves one cycle after the frame select rise is seen
  // a select fall outranks everything else in its cycle
  // a select fall during the last bit therefore loses that frame
  // link clock falls outside a frame leave the counter untouched
  // falls after the last bit are ignored until select rises again
  // the link clock must stay high and low for two system cycles at least
  // nothing here runs on the link clock itself

  // ************************************************************
  // helpers
  // ************************************************************
  // true while the sequencer is taking bits
  function automatic logic is_shifting(input dac_frame_pkg::frame_state_type st);
    is_shifting = (st == dac_frame_pkg::ST_SHIFT);
  endfunction : is_shifting

  // ************************************************************
  // elaboration check
  // ************************************************************
  initial begin
    if (FRAME_LEN != `FRAME_LEN_WIDE && FRAME_LEN != `FRAME_LEN_NARROW)
      $error("frame length must be 24 or 16");
    // edge finding needs two system samples per link clock period
    if (`LINK_CLK_MIN_SYS_CYC < 2)
      $error("system clock too slow for the link clock");
  end

  // ************************************************************
  // pin synchronisation
  // ************************************************************
  dac_frame_pkg::link_pins_type pins_s;
  logic [2:0]                   pins_s_raw;
  logic                         frame_n_d_r;
  logic                         link_clk_d_r;
  logic                         clk_fall;
  logic                         sel_fall;
  logic                         sel_rise;

  pin_sync #(
    .WIDTH (3)
  ) u_sync (
    .i_sys_clk   (i_sys_clk),
    .i_rst_b     (i_rst_b),
    .i_async     (i_pins),
    .i_reset_val (3'h7),
    .o_sync      (pins_s_raw)
  );
  assign pins_s = dac_frame_pkg::link_pins_type'(pins_s_raw);

  // delayed copies of synchronised pins for edge finding
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      frame_n_d_r  <= 1'b1;
      link_clk_d_r <= 1'b1;
    end else begin
      frame_n_d_r  <= pins_s.frame_n;
      link_clk_d_r <= pins_s.link_clk;
    end
  end

  // edges seen at the system clock; link clock is at most one fifth of it
  assign clk_fall = link_clk_d_r & ~pins_s.link_clk; // RL6
  assign sel_fall = frame_n_d_r & ~pins_s.frame_n;
  assign sel_rise = ~frame_n_d_r & pins_s.frame_n;

  // ************************************************************
  // frame state and bit counter
  // ************************************************************
  dac_frame_pkg::frame_state_type state_r;
  dac_frame_pkg::frame_state_type state_nxt;
  logic [CNT_W-1:0]               bit_cnt_r;
  logic [FRAME_LEN-1:0]           shift_r;
  logic                           last_bit;
  logic                           shift_en;

  // counter points at the final bit of the frame
  assign last_bit = (bit_cnt_r == CNT_W'(FRAME_LEN - 1));

  // one bit is taken this cycle, unless the frame is being dropped
  assign shift_en = is_shifting(state_r) && !sel_rise && clk_fall;

  // next state of the frame sequencer
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      dac_frame_pkg::ST_IDLE: begin
        if (sel_fall) begin
          state_nxt = dac_frame_pkg::ST_SHIFT; // RL3
        end
      end
      dac_frame_pkg::ST_SHIFT: begin
        if (sel_rise) begin
          state_nxt = dac_frame_pkg::ST_IDLE; // RL5
        end else if (clk_fall && last_bit) begin
          state_nxt = dac_frame_pkg::ST_DONE; // RL4
        end
      end
      dac_frame_pkg::ST_DONE: begin
        if (sel_rise) begin
          state_nxt = dac_frame_pkg::ST_IDLE;
        end
      end
      default: begin
        state_nxt = dac_frame_pkg::ST_IDLE;
      end
    endcase
  end

  // state register
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state_r <= dac_frame_pkg::ST_IDLE;
    end else if (sel_fall) begin
      state_r <= dac_frame_pkg::ST_SHIFT; // RL7
    end else begin
      state_r <= state_nxt;
    end
  end

  // bit counter, cleared by every frame select fall
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      bit_cnt_r <= '0;
    end else if (sel_fall) begin
      bit_cnt_r <= '0; // RL7
    end else if (shift_en) begin
      bit_cnt_r <= bit_cnt_r + CNT_W'(1); // RL4
    end
  end

  // ************************************************************
  // shift register and converter word
  // ************************************************************
  // data sampled msb first on each falling link clock edge while shifting
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      shift_r <= '0;
    end else if (is_shifting(state_r) && !pins_s.frame_n && clk_fall) begin
      shift_r <= {shift_r[FRAME_LEN-2:0], pins_s.data}; // RL1 RL2
    end
  end

  // converter word loaded only on a completed frame
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_dac_word   <= FRAME_LEN'(`DATA_RESET);
      o_dac_update <= 1'b0;
    end else begin
      o_dac_update <= 1'b0;
      if (shift_en && !sel_fall && last_bit) begin
        o_dac_word   <= {shift_r[FRAME_LEN-2:0], pins_s.data}; // RL4
        o_dac_update <= 1'b1; // RL4
      end
    end
  end

  // abort flag pulses when a partial frame is dropped
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_frame_abort <= 1'b0;
    end else begin
      o_frame_abort <= is_shifting(state_r) && sel_rise; // RL5
    end
  end

  // frame open and still taking bits
  assign o_frame_active = is_shifting(state_r); // RL3
endmodule : serial_dac_input_frame

// ### testbench/dac_frame_monitor.sv
// port checks for the serial converter input frame
`timescale 1ns/1ps
module dac_frame_monitor #(
  parameter int FRAME_LEN = 24
) (
  input wire logic                         i_sys_clk,
  input wire logic                         i_rst_b,
  input wire dac_frame_pkg::link_pins_type i_pins,
  input wire logic [FRAME_LEN-1:0]         o_dac_word,
  input wire logic                         o_dac_update,
  input wire logic                         o_frame_abort,
  input wire logic                         o_frame_active
);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_b);
  AST_ONE_END: assert property (!(o_dac_update && o_frame_abort))
    else $error("update with abort");
  AST_UPD_PULSE: assert property (o_dac_update |=> !o_dac_update)
    else $error("long update");
  AST_ABT_PULSE: assert property (o_frame_abort |=> !o_frame_abort)
    else $error("long abort");
  AST_WORD_HOLD: assert property ($changed(o_dac_word) |-> o_dac_update)
    else $error("word moved");
  AST_ABT_IDLE: assert property (o_frame_abort |-> !o_frame_active)
    else $error("active after abort");
  AST_UPD_ACT: assert property (o_dac_update |-> $past(o_frame_active))
    else $error("update outside frame");
  AST_OPEN: assert property ($fell(i_pins.frame_n) |-> ##[2:4] o_frame_active)
    else $error("frame not opened");
  AST_IDLE: assert property (i_pins.frame_n [*5] |-> !o_frame_active)
    else $error("active while deselected");
  cover property (o_dac_update);
  cover property (o_frame_abort);
  cover property ($rose(o_frame_active));
endmodule : dac_frame_monitor
bind serial_dac_input_frame dac_frame_monitor #(.FRAME_LEN(FRAME_LEN)) u_dac_frame_monitor (
  .i_sys_clk(i_sys_clk), .i_rst_b(i_rst_b), .i_pins(i_pins), .o_dac_word(o_dac_word),
  .o_dac_update(o_dac_update), .o_frame_abort(o_frame_abort),
  .o_frame_active(o_frame_active));

// ### testbench/link_host.sv
// host model driving the three-wire link
`timescale 1ns/1ps
module link_host (
  input  wire logic                    i_sys_clk,
  output dac_frame_pkg::link_pins_type o_pins
);
  initial o_pins = 3'b110;
  // one link clock phase of 24 ns, 48 ns period
  task automatic half();
    repeat (6) @(posedge i_sys_clk);
    #1;
  endtask : half
  // top bits of w msb first, frame select rises after cut bits
  task automatic send(input logic [23:0] w, input int cut);
    o_pins.frame_n = 1'b0;
    for (int i = 0; i < cut; i++) begin
      o_pins.data = w[23-i];
      half();
      o_pins.link_clk = 1'b0;
      half();
      o_pins.link_clk = 1'b1;
    end
    half();
    o_pins.frame_n = 1'b1;
    o_pins.data = ~o_pins.data; // released line shows the inverse
  endtask : send
endmodule : link_host

// ### testbench/tb.sv
// testbench for the serial converter input frame
`timescale 1ns/1ps
module tb;
  logic                         i_sys_clk = 1'b0;
  logic                         i_rst_b = 1'b0;
  dac_frame_pkg::link_pins_type pins;
  logic [23:0]                  word;
  logic [23:0]                  last = 24'h000000;
  logic                         upd;
  logic                         abt;
  logic                         act;
  int fails = 0, num_checks = 0, n_upd = 0, n_abt = 0, n_act = 0, cyc = 0;
  always #2 i_sys_clk = ~i_sys_clk;
  link_host u_link_host (.i_sys_clk(i_sys_clk), .o_pins(pins));
  serial_dac_input_frame #(.FRAME_LEN(24)) u_serial_dac_input_frame (.i_sys_clk(i_sys_clk),
    .i_rst_b(i_rst_b), .i_pins(pins), .o_dac_word(word), .o_dac_update(upd),
    .o_frame_abort(abt), .o_frame_active(act));
  // pulse counters and hang guard
  always @(posedge i_sys_clk) begin
    n_upd <= n_upd + int'(upd === 1'b1);
    n_abt <= n_abt + int'(abt === 1'b1);
    n_act <= n_act + int'(act === 1'b1);
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fails++;
      test_done();
    end
  end
  task automatic test_done();
    $display("checks %0d fails %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : test_done
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  // send cut bits of w, then judge word and pulse counts
  task automatic frame(input logic [23:0] w, input int cut);
    int u;
    int a;
    int t;
    u = n_upd;
    a = n_abt;
    t = n_act;
    u_link_host.send(w, cut);
    repeat (8) @(posedge i_sys_clk);
    #1;
    if (cut == 24) last = w;
    chk(word, last);
    chk(24'(n_upd - u), 24'(cut == 24));
    chk(24'(n_abt - a), 24'(cut < 24));
    chk(24'(n_act > t), 24'h000001);
    chk(24'(act === 1'b1), 24'h000000);
  endtask : frame
  initial begin
    repeat (2) @(posedge i_sys_clk);
    #1;
    i_rst_b = 1'b1;
    chk(word, 24'h000000);
    frame(24'ha5c30f, 24);
    frame(24'h3c5a96, 23);
    frame(24'h5a3cf1, 24);
    frame(24'h0ff0e1, 1);
    frame(24'hffffff, 24);
    test_done();
  end
endmodule : tb
